/* core/mic_pkg.sv */
/*
 mic_pkg: constants shared by the interrupt controller, its core model and the testbench.
 assumes a 32-bit AXI4-Lite register bus with byte address = register index * 4.
*/
package mic_pkg;
	// register indexes, byte address is index * 4
	localparam logic [7:0] IDX_FLAGS_LO = 8'h97;
	localparam logic [7:0] IDX_FLAGS_HI = 8'h98;
	localparam logic [7:0] IDX_EN_LO = 8'h9A;
	localparam logic [7:0] IDX_EN_HI = 8'h9B;
	localparam logic [7:0] IDX_STACK_CTRL = 8'hEF;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;
	localparam int ADDR_W = 10;
	// field layout
	localparam int NUM_SRC = 13;
	localparam int LO_BITS = 8;
	localparam int HI_BITS = 5;
	localparam int GIE_BIT = 7;
	localparam int LVD_HI_BIT = 6;
	localparam int LVD_LO_BIT = 5;
	localparam int STACK_AND_GLOBAL_CTRL_W = 3;
	localparam logic [2:0] STACK_AND_GLOBAL_CTRL_RESET = 3'h7;
	localparam logic [2:0] STACK_AND_GLOBAL_CTRL_ONE = 3'h1;
	// source bit order of flags, enables and events
	localparam int SRC_EXT_A = 0;
	localparam int SRC_EXT_B = 1;
	localparam int SRC_TIMER_A = 2;
	localparam int SRC_WAKE = 8;
	// controller's own event bits
	localparam int EVT_ENTRY = 0;
	localparam int EVT_EXIT = 1;
	localparam int EVT_W = 2;
	// vector per source, lowest vector wins
	localparam logic [7:0] VEC_MIN = 8'h08;
	localparam logic [7:0] VEC_MAX = 8'h0E;
	localparam logic [8*NUM_SRC-1:0] VEC_TABLE = {
		8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h08,
		8'h0E, 8'h0E, 8'h0E, 8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h09};
	// context: accumulator plus working registers 0x80..0x8F
	localparam int CTX_WORDS = 17;
	localparam int CTX_AW = 5;
	localparam logic [4:0] CTX_LAST = 5'h10;
	localparam logic [4:0] CTX_FIRST = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MIC_IDLE = 3'b000,
		MIC_SAVE = 3'b001,
		MIC_VECT = 3'b010,
		MIC_SERV = 3'b011,
		MIC_REST = 3'b100,
		MIC_DONE = 3'b101
	} mic_fsm_t;
endpackage

/* core/mic_ctx_mem.sv */
/*
 mic_ctx_mem: shadow buffer for the saved core context, one write and one
 registered read port. assumes the controller never reads and writes one word at once.
*/
`timescale 1ns/1ps
`default_nettype none
module mic_ctx_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 17,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array: contents are only read after a save
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

/* core/mic_intc.sv */
/*
 mic_intc: interrupt controller of an 8-bit core, with AXI4-Lite registers.
 assumes one-cycle source event pulses synchronous to CORE_CLK, a core that
 answers CTX_RDATA for CTX_ADDR in the same cycle, and pulses RETURN_FROM_INTERRUPT_EXEC once.
*/
// How it works
// - thirteen sources: two external pins and eleven internal events
// - external request stays pending through power-down until the core runs again
// - entering service clears global enable
// - finishing service sets global enable again
// - an event sets its flag whatever its enable holds
// - vector only when enable, flag and global enable are all one
// - accumulator and working registers 0x80-0x8F saved before vector load
// - RAM bank left as the main routine had it on entry
// - return reloads accumulator and working registers from the shadow buffer
// - accept pushes stack one level and loads vector 8 to 14
// - first enable register at 09AH, reset zero, low source order
// - second enable register at 09BH, five enables, upper bits unused
// - first flag register at 097H; hardware sets, software clears
// - second flag register at 098H holds the five high flags
// - global enable is bit 7 at 0EFH, reset zero, gates all vectoring
// - wakeup flag set on wake; vector 8 when enabled
// - external sources vector to 0x0009 and 0x000A
`timescale 1ns/1ps
`default_nettype none
module mic_intc
	import mic_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// register bus
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// sources and core status
	input wire logic [NUM_SRC-1:0] SRC_EVENT,
	input wire logic CORE_SLEEP,
	input wire logic LVD_HI,
	input wire logic LVD_LO,
	input wire logic RETURN_FROM_INTERRUPT_EXEC,
	// core context and program counter
	output logic [CTX_AW-1:0] CTX_ADDR,
	input wire logic [7:0] CTX_RDATA,
	output logic CTX_WE,
	output logic [7:0] CTX_WDATA,
	output logic PC_LOAD,
	output logic [7:0] PC_VECTOR,
	output logic STACK_PUSH,
	output logic STACK_POP,
	// interrupt line
	output logic IRQ
);
	typedef struct packed {
		logic [NUM_SRC-1:0] flags;
		logic [NUM_SRC-1:0] enables;
		logic global_irq_enable;
		logic [STACK_AND_GLOBAL_CTRL_W-1:0] stack_and_global_ctrl;
		logic [EVT_W-1:0] status;
		logic [EVT_W-1:0] mask;
		logic irq;
		mic_fsm_t fsm;
		logic [CTX_AW-1:0] ptr;
		logic [CTX_AW-1:0] ctx_addr;
		logic ctx_we;
		logic [7:0] vector;
		logic pc_load;
		logic push;
		logic pop;
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mic_state_t;

	mic_state_t s;
	mic_state_t n;
	logic [NUM_SRC-1:0] pending;
	logic [7:0] best_vec;
	logic [7:0] widx;
	logic [7:0] ridx;
	logic accept;
	logic [EVT_W-1:0] evt;

	// lowest vector among enabled pending sources, ties to lowest bit
	always_comb begin
		best_vec = VEC_MAX;
		pending = s.flags & s.enables;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i] && VEC_TABLE[8*i +: 8] <= best_vec) begin
				best_vec = VEC_TABLE[8*i +: 8];
			end
		end
	end

	// sleeping core cannot be vectored, so the latched request waits
	assign accept = (s.fsm == MIC_IDLE) && s.global_irq_enable && !CORE_SLEEP && (|pending);
	// index is the byte address without its two low bits
	assign widx = 8'(s.awaddr[ADDR_W-1:2]);
	assign ridx = 8'(ARADDR[ADDR_W-1:2]);

	always_comb begin
		n = s;
		evt = '0;
		n.pc_load = 1'b0;
		n.push = 1'b0;
		n.pop = 1'b0;
		n.ctx_we = 1'b0;
		// write channel, address and data in either order
		if (s.awready && AWVALID) begin
			n.aw_held = 1'b1;
			n.awaddr = AWADDR;
		end
		if (s.wready && WVALID) begin
			n.w_held = 1'b1;
			n.wdata = WDATA;
			n.wstrb = WSTRB;
		end
		if (s.bvalid && BREADY) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			unique case (widx)
				IDX_FLAGS_LO: begin
					if (s.wstrb[0]) n.flags[LO_BITS-1:0] = s.wdata[LO_BITS-1:0];
				end
				IDX_FLAGS_HI: begin
					if (s.wstrb[0]) n.flags[NUM_SRC-1:LO_BITS] = s.wdata[HI_BITS-1:0];
				end
				IDX_EN_LO: begin
					if (s.wstrb[0]) n.enables[LO_BITS-1:0] = s.wdata[LO_BITS-1:0];
				end
				IDX_EN_HI: begin
					if (s.wstrb[0]) n.enables[NUM_SRC-1:LO_BITS] = s.wdata[HI_BITS-1:0];
				end
				IDX_STACK_CTRL: begin
					if (s.wstrb[0]) begin
						n.global_irq_enable = s.wdata[GIE_BIT];
						n.stack_and_global_ctrl = s.wdata[STACK_AND_GLOBAL_CTRL_W-1:0];
					end
				end
				IDX_IRQ_MASK: begin
					if (s.wstrb[0]) n.mask = s.wdata[EVT_W-1:0];
				end
				IDX_IRQ_STATUS: begin
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end
		// read channel
		if (s.rvalid && RREADY) begin
			n.rvalid = 1'b0;
		end
		if (s.arready && ARVALID) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = '0;
			unique case (ridx)
				IDX_FLAGS_LO: n.rdata[LO_BITS-1:0] = s.flags[LO_BITS-1:0];
				IDX_FLAGS_HI: n.rdata[HI_BITS-1:0] = s.flags[NUM_SRC-1:LO_BITS];
				IDX_EN_LO: n.rdata[LO_BITS-1:0] = s.enables[LO_BITS-1:0];
				IDX_EN_HI: n.rdata[HI_BITS-1:0] = s.enables[NUM_SRC-1:LO_BITS];
				IDX_STACK_CTRL: begin
					n.rdata[GIE_BIT] = s.global_irq_enable;
					n.rdata[LVD_HI_BIT] = LVD_HI;
					n.rdata[LVD_LO_BIT] = LVD_LO;
					n.rdata[STACK_AND_GLOBAL_CTRL_W-1:0] = s.stack_and_global_ctrl;
				end
				IDX_IRQ_STATUS: begin
					n.rdata[EVT_W-1:0] = s.status;
					n.status = '0;
				end
				IDX_IRQ_MASK: n.rdata[EVT_W-1:0] = s.mask;
				default: n.rresp = RESP_SLVERR;
			endcase
		end
		// service sequence
		unique case (s.fsm)
			MIC_IDLE: begin
				if (accept) begin
					n.global_irq_enable = 1'b0;
					n.vector = best_vec;
					n.ctx_addr = CTX_FIRST;
					n.fsm = MIC_SAVE;
					evt[EVT_ENTRY] = 1'b1;
				end
			end
			MIC_SAVE: begin
				// buffer write happens in the memory, bank register saved as plain data
				n.ctx_addr = s.ctx_addr + 5'h01;
				if (s.ctx_addr == CTX_LAST) begin
					n.fsm = MIC_VECT;
				end
			end
			MIC_VECT: begin
				n.pc_load = 1'b1;
				n.push = 1'b1;
				n.stack_and_global_ctrl = s.stack_and_global_ctrl + STACK_AND_GLOBAL_CTRL_ONE;
				n.fsm = MIC_SERV;
			end
			MIC_SERV: begin
				if (RETURN_FROM_INTERRUPT_EXEC) begin
					n.ptr = CTX_FIRST;
					n.fsm = MIC_REST;
				end
			end
			MIC_REST: begin
				n.ctx_addr = s.ptr;
				n.ctx_we = 1'b1;
				n.ptr = s.ptr + 5'h01;
				if (s.ptr == CTX_LAST) begin
					n.fsm = MIC_DONE;
				end
			end
			MIC_DONE: begin
				n.global_irq_enable = 1'b1;
				n.pop = 1'b1;
				n.stack_and_global_ctrl = s.stack_and_global_ctrl - STACK_AND_GLOBAL_CTRL_ONE;
				n.fsm = MIC_IDLE;
				evt[EVT_EXIT] = 1'b1;
			end
			default: n.fsm = MIC_IDLE;
		endcase
		// hardware set wins over software clear in the same cycle
		n.flags = n.flags | SRC_EVENT;
		n.status = n.status | evt;
		n.irq = |(n.status & n.mask);
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
			s.fsm <= MIC_IDLE;
			s.stack_and_global_ctrl <= STACK_AND_GLOBAL_CTRL_RESET;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// single buffer: nested service is impossible since accept requires MIC_IDLE
	mic_ctx_mem #(
		.WIDTH(8),
		.DEPTH(CTX_WORDS),
		.AW(CTX_AW)
	) u_ctx (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.wr_en(s.fsm == MIC_SAVE),
		.wr_addr(s.ctx_addr),
		.wr_data(CTX_RDATA),
		.rd_addr(s.ptr),
		.rd_data(CTX_WDATA)
	);

	assign AWREADY = s.awready;
	assign WREADY = s.wready;
	assign BVALID = s.bvalid;
	assign BRESP = s.bresp;
	assign ARREADY = s.arready;
	assign RVALID = s.rvalid;
	assign RDATA = s.rdata;
	assign RRESP = s.rresp;
	assign CTX_ADDR = s.ctx_addr;
	assign CTX_WE = s.ctx_we;
	assign PC_LOAD = s.pc_load;
	assign PC_VECTOR = s.vector;
	assign STACK_PUSH = s.push;
	assign STACK_POP = s.pop;
	assign IRQ = s.irq;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);

	a_gie_clear_entry: assert property ($rose(s.fsm == MIC_SAVE) |-> !s.global_irq_enable)
		else $error("global enable not cleared on entry");
	a_gie_set_exit: assert property (s.fsm == MIC_DONE |=> s.global_irq_enable && s.fsm == MIC_IDLE)
		else $error("global enable not restored on exit");
	a_flag_sets: assert property (|SRC_EVENT |=> (s.flags & $past(SRC_EVENT)) == $past(SRC_EVENT))
		else $error("event did not set its flag");
	a_no_vector_idle: assert property (s.fsm == MIC_IDLE && !(|(s.flags & s.enables)) |=> s.fsm == MIC_IDLE)
		else $error("vectoring without an enabled request");
	a_gie_gate: assert property (s.fsm == MIC_IDLE && !s.global_irq_enable |=> s.fsm == MIC_IDLE)
		else $error("vectoring with global enable off");
	a_sleep_hold: assert property (s.fsm == MIC_IDLE && CORE_SLEEP |=> s.fsm == MIC_IDLE)
		else $error("vectoring while the core sleeps");
	a_save_then_load: assert property ($rose(s.fsm == MIC_SAVE) |-> !PC_LOAD [*8] ##11 PC_LOAD)
		else $error("vector load not after the full save");
	a_push_vector: assert property (PC_LOAD |-> STACK_PUSH && PC_VECTOR >= VEC_MIN && PC_VECTOR <= VEC_MAX)
		else $error("push or vector range wrong");
	a_stack_step: assert property (PC_LOAD |-> s.stack_and_global_ctrl == $past(s.stack_and_global_ctrl) + STACK_AND_GLOBAL_CTRL_ONE)
		else $error("stack not one level deeper");
	a_restore_seq: assert property ($rose(s.fsm == MIC_REST) |=> CTX_WE [*8] ##10 STACK_POP)
		else $error("context reload or pop out of step");
	a_resp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");

	c_entry: cover property (PC_LOAD);
	c_exit: cover property (STACK_POP);
	c_two_pending: cover property (PC_LOAD && $countones(s.flags & s.enables) > 1);
	c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

/* test/mic_core_model.sv */
/*
 mic_core_model: core side of the controller, holding the accumulator and
 working registers and counting stack levels.
 assumes CTX_ADDR 0..16 and a bench that may overwrite mem between save and restore.
*/
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
	import mic_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// context bus
	input wire logic [CTX_AW-1:0] ctx_addr,
	output logic [7:0] ctx_rdata,
	input wire logic ctx_we,
	input wire logic [7:0] ctx_wdata,
	// stack
	input wire logic stack_push,
	input wire logic stack_pop
);
	logic [7:0] mem [CTX_WORDS];
	int depth;
	int restores;
	// out of range answers a moving count, so a stale byte never looks valid
	assign ctx_rdata = (ctx_addr <= CTX_LAST) ? mem[ctx_addr] : 8'(restores);
	initial begin
		for (int i = 0; i < CTX_WORDS; i++) begin
			mem[i] = 8'(8'h30 + i);
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			depth <= 0;
			restores <= 0;
		end else begin
			if (ctx_we) begin
				mem[ctx_addr] <= ctx_wdata;
				restores <= restores + 1;
			end
			depth <= depth + int'(stack_push) - int'(stack_pop);
		end
	end
endmodule
`default_nettype wire

/* test/tb_mcu_interrupt_controller.sv */
/*
 tb_mcu_interrupt_controller: registers, vectoring, context and wake scenarios.
 assumes mic_intc with mic_core_model on its core side, byte address = index * 4.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_interrupt_controller
	import mic_pkg::*;
;
	logic CORE_CLK = 0, RSTN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic CORE_SLEEP = 0, LVD_HI = 1, LVD_LO = 0, RETURN_FROM_INTERRUPT_EXEC = 0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CTX_WE, PC_LOAD, STACK_PUSH, STACK_POP, IRQ;
	logic [9:0] AWADDR = '0, ARADDR = '0;
	logic [31:0] WDATA = '0, RDATA;
	logic [3:0] WSTRB = '0;
	logic [1:0] BRESP, RRESP;
	logic [12:0] SRC_EVENT = '0;
	logic [4:0] CTX_ADDR;
	logic [7:0] CTX_RDATA, CTX_WDATA, PC_VECTOR;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	mic_intc i_mic_intc (.CORE_CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
		.RRESP, .RVALID, .RREADY, .SRC_EVENT, .CORE_SLEEP, .LVD_HI, .LVD_LO, .RETURN_FROM_INTERRUPT_EXEC,
		.CTX_ADDR, .CTX_RDATA, .CTX_WE, .CTX_WDATA, .PC_LOAD, .PC_VECTOR, .STACK_PUSH,
		.STACK_POP, .IRQ);
	mic_core_model i_mic_core_model (.clk(CORE_CLK), .rst_n(RSTN), .ctx_addr(CTX_ADDR),
		.ctx_rdata(CTX_RDATA), .ctx_we(CTX_WE), .ctx_wdata(CTX_WDATA),
		.stack_push(STACK_PUSH), .stack_pop(STACK_POP));
	always #25 CORE_CLK = ~CORE_CLK;
	// about 1000 cycles are needed; the ceiling leaves ample slack
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	task results;
		if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		AWADDR <= {idx, 2'b00};
		WDATA <= {24'h00_0000, d};
		WSTRB <= 4'hf;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		// ready stays high between transfers, so back to back calls never drive it twice
		forever begin
			@(posedge CORE_CLK);
			if (AWREADY === 1'b1) AWVALID <= 0;
			if (WREADY === 1'b1) WVALID <= 0;
			if (BVALID === 1'b1) break;
		end
		chk(BVALID, 1);
		chk(BRESP, RESP_OKAY);
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		ARADDR <= {idx, 2'b00};
		ARVALID <= 1;
		RREADY <= 1;
		forever begin
			@(posedge CORE_CLK);
			if (ARREADY === 1'b1) ARVALID <= 0;
			if (RVALID === 1'b1) break;
		end
		chk(RVALID, 1);
		chk(RDATA, exp);
		chk(RRESP, er);
	endtask
	task ev(input logic [12:0] b);
		SRC_EVENT <= b;
		@(posedge CORE_CLK);
		SRC_EVENT <= '0;
	endtask
	task nopc;
		int n;
		n = 0;
		repeat (30) begin
			@(posedge CORE_CLK);
			if (PC_LOAD !== 1'b0) n++;
		end
		chk(n, 0);
	endtask
	task wpc(input logic [7:0] v);
		repeat (60) begin
			@(posedge CORE_CLK);
			if (PC_LOAD === 1'b1) break;
		end
		chk(PC_LOAD, 1);
		chk(PC_VECTOR, v);
		chk(STACK_PUSH, 1);
		chk(i_mic_core_model.restores, 0);
	endtask
	// return, after spoiling the core's copy so only the restore can bring it back
	task ret;
		chk(i_mic_core_model.depth, 1);
		for (int i = 0; i < CTX_WORDS; i++) i_mic_core_model.mem[i] = 8'hff;
		RETURN_FROM_INTERRUPT_EXEC <= 1;
		@(posedge CORE_CLK);
		RETURN_FROM_INTERRUPT_EXEC <= 0;
		repeat (40) begin
			@(posedge CORE_CLK);
			if (STACK_POP === 1'b1) break;
		end
		chk(STACK_POP, 1);
		@(posedge CORE_CLK);
		chk(i_mic_core_model.depth, 0);
		chk(i_mic_core_model.restores, CTX_WORDS);
		for (int i = 0; i < CTX_WORDS; i++) chk(i_mic_core_model.mem[i], 8'h30 + i);
		i_mic_core_model.restores = 0;
	endtask
	task t_reset;
		rd(IDX_FLAGS_LO, 0, RESP_OKAY);
		rd(IDX_FLAGS_HI, 0, RESP_OKAY);
		rd(IDX_EN_LO, 0, RESP_OKAY);
		rd(IDX_EN_HI, 0, RESP_OKAY);
		rd(IDX_STACK_CTRL, 32'h0000_0047, RESP_OKAY);
		LVD_HI <= 0;
		LVD_LO <= 1;
		rd(IDX_STACK_CTRL, 32'h0000_0027, RESP_OKAY);
		LVD_HI <= 1;
		LVD_LO <= 0;
		rd(IDX_IRQ_MASK, 0, RESP_OKAY);
		rd(8'h00, 0, RESP_SLVERR);
		wr(IDX_EN_HI, 8'hff);
		rd(IDX_EN_HI, 32'h0000_001f, RESP_OKAY);
		wr(IDX_EN_LO, 8'hff);
		rd(IDX_EN_LO, 32'h0000_00ff, RESP_OKAY);
	endtask
	task t_flags;
		ev(13'h1fff);
		nopc();
		rd(IDX_FLAGS_LO, 32'h0000_00ff, RESP_OKAY);
		rd(IDX_FLAGS_HI, 32'h0000_001f, RESP_OKAY);
		wr(IDX_EN_LO, 8'h00);
		wr(IDX_EN_HI, 8'h00);
		wr(IDX_STACK_CTRL, 8'h87);
		nopc();
		wr(IDX_FLAGS_LO, 8'h00);
		wr(IDX_FLAGS_HI, 8'h00);
		rd(IDX_FLAGS_LO, 0, RESP_OKAY);
		rd(IDX_FLAGS_HI, 0, RESP_OKAY);
	endtask
	task t_prio;
		wr(IDX_IRQ_MASK, 8'h01);
		wr(IDX_EN_LO, 8'h05);
		ev(13'h0005);
		wpc(8'h09);
		chk(IRQ, 1);
		rd(IDX_STACK_CTRL, 32'h0000_0040, RESP_OKAY);
		rd(IDX_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
		repeat (2) @(posedge CORE_CLK);
		chk(IRQ, 0);
		wr(IDX_FLAGS_LO, 8'h04);
		ret();
		wpc(8'h0b);
		wr(IDX_FLAGS_LO, 8'h00);
		ret();
		rd(IDX_STACK_CTRL, 32'h0000_00c7, RESP_OKAY);
		wr(IDX_IRQ_MASK, 8'h00);
		repeat (2) @(posedge CORE_CLK);
		chk(IRQ, 0);
		rd(IDX_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
	endtask
	task t_vec;
		wr(IDX_EN_LO, 8'hff);
		wr(IDX_EN_HI, 8'h1f);
		for (int i = 0; i < NUM_SRC; i++) begin
			ev(13'h0001 << i);
			wpc((i == 8) ? 8'h08 : (i < 5) ? 8'(9 + i) : 8'h0e);
			wr(IDX_FLAGS_LO, 8'h00);
			wr(IDX_FLAGS_HI, 8'h00);
			ret();
		end
	endtask
	task t_wake;
		wr(IDX_EN_LO, 8'h01);
		wr(IDX_EN_HI, 8'h01);
		CORE_SLEEP <= 1;
		ev(13'h0101);
		nopc();
		CORE_SLEEP <= 0;
		wpc(8'h08);
		wr(IDX_FLAGS_HI, 8'h00);
		ret();
		wpc(8'h09);
		wr(IDX_FLAGS_LO, 8'h00);
		ret();
	endtask
	initial begin
		repeat (12) @(posedge CORE_CLK);
		RSTN <= 1;
		@(posedge CORE_CLK);
		t_reset();
		t_flags();
		t_prio();
		t_vec();
		t_wake();
		results();
	end
endmodule
`default_nettype wire
